// ### core/dma_channel_regs.sv
`include "dma_channel_map.svh"
`default_nettype none
module dma_channel_regs
  import dma_channel_pkg::*;
#(
  parameter int PTR_W = 32,
  parameter int CNT_W = 16
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             sel_i,
  input  wire logic             write_i,
  input  wire logic [11:0]      addr_i,
  input  wire logic [31:0]      wdata_i,
  output logic [31:0]           rdata_o,
  input  wire logic             rx_request_i,
  input  wire logic             tx_request_i,
  input  wire xfer_size_t       rx_size_i,
  input  wire xfer_size_t       tx_size_i,
  input  wire logic             rx_done_i,
  input  wire logic             tx_done_i,
  output logic                  rx_start_o,
  output logic                  tx_start_o,
  output logic [PTR_W-1:0]      rx_addr_o,
  output logic [PTR_W-1:0]      tx_addr_o,
  output logic                  rx_end_o,
  output logic                  tx_end_o
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic             rst_meta;
  logic             rst_sync_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic             wr;
  logic             rd;
  logic             wr_ctrl;
  logic             rx_enable;
  logic             tx_enable;
  logic             rx_start;
  logic             tx_start;
  logic             rx_end;
  logic             tx_end;
  logic [PTR_W-1:0] rx_ptr;
  logic [PTR_W-1:0] tx_ptr;
  logic [PTR_W-1:0] rx_nptr;
  logic [PTR_W-1:0] tx_nptr;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] rx_ncnt;
  logic [CNT_W-1:0] tx_ncnt;
  logic [31:0]      next_rdata;

  assign wr = sel_i && write_i;
  assign rd = sel_i && !write_i;
  assign wr_ctrl = wr && (addr_i == `OFS_TRANSFER_ENABLE_CTRL);

  // ---------------------------------------------------------------
  // Channel instances
  // ---------------------------------------------------------------
  // receive offsets
  dma_half_channel #(.PTR_W(PTR_W), .CNT_W(CNT_W)) u_rx
  (
    .clk_i     (ref_clk_i),
    .rst_n_i   (rst_sync_n),
    .wr_ptr_i  (wr && addr_i == `OFS_RX_BUFFER_POINTER),
    .wr_cnt_i  (wr && addr_i == `OFS_RX_TRANSFER_COUNT),
    .wr_nptr_i (wr && addr_i == `OFS_RX_NEXT_BUFFER_POINTER),
    .wr_ncnt_i (wr && addr_i == `OFS_RX_NEXT_TRANSFER_COUNT),
    .wdata_i   (wdata_i),
    .enable_i  (rx_enable),
    .request_i (rx_request_i),
    .size_i    (rx_size_i),
    .done_i    (rx_done_i),
    .start_o   (rx_start),
    .ptr_o     (rx_ptr),
    .cnt_o     (rx_cnt),
    .nptr_o    (rx_nptr),
    .ncnt_o    (rx_ncnt),
    .end_o     (rx_end)
  );

  dma_half_channel #(.PTR_W(PTR_W), .CNT_W(CNT_W)) u_tx
  (
    .clk_i     (ref_clk_i),
    .rst_n_i   (rst_sync_n),
    .wr_ptr_i  (wr && addr_i == `OFS_TX_BUFFER_POINTER),
    .wr_cnt_i  (wr && addr_i == `OFS_TX_TRANSFER_COUNT),
    .wr_nptr_i (wr && addr_i == `OFS_TX_NEXT_BUFFER_POINTER),
    .wr_ncnt_i (wr && addr_i == `OFS_TX_NEXT_TRANSFER_COUNT),
    .wdata_i   (wdata_i),
    .enable_i  (tx_enable),
    .request_i (tx_request_i),
    .size_i    (tx_size_i),
    .done_i    (tx_done_i),
    .start_o   (tx_start),
    .ptr_o     (tx_ptr),
    .cnt_o     (tx_cnt),
    .nptr_o    (tx_nptr),
    .ncnt_o    (tx_ncnt),
    .end_o     (tx_end)
  );

  // ---------------------------------------------------------------
  // Transfer enable control
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // Disable wins over enable
      if (wdata_i[`POS_RX_DISABLE])
        rx_enable <= 1'b0;
      else if (wdata_i[`POS_RX_ENABLE])
        rx_enable <= 1'b1;
      if (wdata_i[`POS_TX_DISABLE])
        tx_enable <= 1'b0;
      else if (wdata_i[`POS_TX_ENABLE])
        tx_enable <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr_i)
      `OFS_RX_BUFFER_POINTER:      next_rdata = 32'(rx_ptr);
      `OFS_RX_TRANSFER_COUNT:      next_rdata = 32'(rx_cnt);
      `OFS_TX_BUFFER_POINTER:      next_rdata = 32'(tx_ptr);
      `OFS_TX_TRANSFER_COUNT:      next_rdata = 32'(tx_cnt);
      `OFS_RX_NEXT_BUFFER_POINTER: next_rdata = 32'(rx_nptr);
      `OFS_RX_NEXT_TRANSFER_COUNT: next_rdata = 32'(rx_ncnt);
      `OFS_TX_NEXT_BUFFER_POINTER: next_rdata = 32'(tx_nptr);
      `OFS_TX_NEXT_TRANSFER_COUNT: next_rdata = 32'(tx_ncnt);
      `OFS_TRANSFER_ENABLE_STATUS:
      begin
        next_rdata[`POS_RX_ENABLE] = rx_enable;
        next_rdata[`POS_TX_ENABLE] = tx_enable;
      end
      default:                     next_rdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rdata_o    <= 32'h0000_0000;
      rx_start_o <= 1'b0;
      tx_start_o <= 1'b0;
      rx_addr_o  <= '0;
      tx_addr_o  <= '0;
      rx_end_o   <= 1'b0;
      tx_end_o   <= 1'b0;
    end
    else
    begin
      rdata_o    <= rd ? next_rdata : 32'h0000_0000;
      rx_start_o <= rx_start;
      tx_start_o <= tx_start;
      rx_addr_o  <= rx_ptr;
      tx_addr_o  <= tx_ptr;
      rx_end_o   <= rx_end;
      tx_end_o   <= tx_end;
    end
  end

  // ---------------------------------------------------------------
  // Register bus checks
  // ---------------------------------------------------------------
  chk_ctrl_reads_zero: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (rd && addr_i == `OFS_TRANSFER_ENABLE_CTRL) |=> (rdata_o == 32'h0))
    else $error("control read not zero");
  chk_status_no_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (wr && addr_i == `OFS_TRANSFER_ENABLE_STATUS)
    |=> ($stable(rx_enable) && $stable(tx_enable)))
    else $error("status write changed state");
  chk_status_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (rd && addr_i == `OFS_TRANSFER_ENABLE_STATUS)
    |=> (rdata_o == {16'h0, 7'h0, $past(tx_enable), 7'h0, $past(rx_enable)}))
    else $error("status read wrong");
  chk_rdata_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    !rd |=> (rdata_o == 32'h0))
    else $error("read data not idle");
  chk_rx_count_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (rd && addr_i == `OFS_RX_TRANSFER_COUNT) |=> (rdata_o == 32'($past(rx_cnt))))
    else $error("rx count read wrong");
  chk_tx_count_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (rd && addr_i == `OFS_TX_TRANSFER_COUNT) |=> (rdata_o == 32'($past(tx_cnt))))
    else $error("tx count read wrong");
  chk_rx_ptr_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (rd && addr_i == `OFS_RX_BUFFER_POINTER) |=> (rdata_o == 32'($past(rx_ptr))))
    else $error("rx pointer read wrong");

  // ---------------------------------------------------------------
  // Transfer checks
  // ---------------------------------------------------------------
  chk_rx_zero_block: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (rx_cnt == '0) |=> !rx_start_o)
    else $error("rx start with zero count");
  chk_tx_zero_block: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (tx_cnt == '0) |=> !tx_start_o)
    else $error("tx start with zero count");
  chk_rx_start_req: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    rx_start |-> (rx_request_i && rx_enable))
    else $error("rx start without request");
  chk_tx_start_req: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    tx_start |-> (tx_request_i && tx_enable))
    else $error("tx start without request");
  chk_rx_start_pulse: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    rx_start_o |=> !rx_start_o)
    else $error("rx start longer than one cycle");
  chk_tx_start_pulse: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    tx_start_o |=> !tx_start_o)
    else $error("tx start longer than one cycle");
  chk_rx_addr_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    1'b1 |=> (rx_addr_o == $past(rx_ptr)))
    else $error("rx address out stale");
  chk_tx_addr_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    1'b1 |=> (tx_addr_o == $past(tx_ptr)))
    else $error("tx address out stale");
  chk_rx_end_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    1'b1 |=> (rx_end_o == $past(rx_end)))
    else $error("rx end out stale");
  chk_tx_end_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    1'b1 |=> (tx_end_o == $past(tx_end)))
    else $error("tx end out stale");
  chk_rx_enable_set: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (wr_ctrl && wdata_i[`POS_RX_ENABLE] && !wdata_i[`POS_RX_DISABLE]) |=> rx_enable)
    else $error("rx enable not set");
  chk_rx_disable_wins: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (wr_ctrl && wdata_i[`POS_RX_DISABLE]) |=> !rx_enable)
    else $error("rx disable ignored");
  chk_tx_disable_wins: assert property (
    @(posedge ref_clk_i) disable iff (!rst_sync_n)
    (wr_ctrl && wdata_i[`POS_TX_DISABLE]) |=> !tx_enable)
    else $error("tx disable ignored");
endmodule
`default_nettype wire

// ### core/dma_channel_map.svh
`ifndef DMA_CHANNEL_MAP_SVH
`define DMA_CHANNEL_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_RX_BUFFER_POINTER      12'h100
`define OFS_RX_TRANSFER_COUNT      12'h104
`define OFS_TX_BUFFER_POINTER      12'h108
`define OFS_TX_TRANSFER_COUNT      12'h10c
`define OFS_RX_NEXT_BUFFER_POINTER 12'h110
`define OFS_RX_NEXT_TRANSFER_COUNT 12'h114
`define OFS_TX_NEXT_BUFFER_POINTER 12'h118
`define OFS_TX_NEXT_TRANSFER_COUNT 12'h11c
`define OFS_TRANSFER_ENABLE_CTRL   12'h120
`define OFS_TRANSFER_ENABLE_STATUS 12'h124

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define POS_RX_ENABLE              0
`define POS_RX_DISABLE             1
`define POS_TX_ENABLE              8
`define POS_TX_DISABLE             9
`define RST_POINTER                32'h0000_0000
`define RST_COUNT                  16'h0000

`endif

// ### core/dma_channel_pkg.sv
`default_nettype none
package dma_channel_pkg;
  // Transfer unit size
  typedef enum logic [1:0]
  {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } xfer_size_t;

  // Engine sequencing
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_XFER  = 2'b01,
    ST_WAIT  = 2'b10
  } chan_state_t;
endpackage
`default_nettype wire

// ### core/dma_half_channel.sv
`include "dma_channel_map.svh"
`default_nettype none
module dma_half_channel
  import dma_channel_pkg::*;
#(
  parameter int PTR_W = 32,
  parameter int CNT_W = 16
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wr_ptr_i,
  input  wire logic             wr_cnt_i,
  input  wire logic             wr_nptr_i,
  input  wire logic             wr_ncnt_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             enable_i,
  input  wire logic             request_i,
  input  wire xfer_size_t       size_i,
  input  wire logic             done_i,
  output logic                  start_o,
  output logic [PTR_W-1:0]      ptr_o,
  output logic [CNT_W-1:0]      cnt_o,
  output logic [PTR_W-1:0]      nptr_o,
  output logic [CNT_W-1:0]      ncnt_o,
  output logic                  end_o
);
  chan_state_t      state;
  logic [PTR_W-1:0] step;
  logic             finish;

  always_comb
  begin
    case (size_i)
      SIZE_HALF: step = PTR_W'(2);
      SIZE_WORD: step = PTR_W'(4);
      default:   step = PTR_W'(1);
    endcase
  end

  // ---------------------------------------------------------------
  // Request gating
  // ---------------------------------------------------------------
  // zero count blocks
  assign start_o = (state == ST_IDLE) && enable_i && request_i && (cnt_o != '0);
  assign finish  = (state == ST_XFER) && done_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE: if (start_o) state <= ST_XFER;
        ST_XFER: if (done_i) state <= ST_WAIT;
        ST_WAIT: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pointer and count registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_o  <= `RST_POINTER;
      cnt_o  <= `RST_COUNT;
      nptr_o <= `RST_POINTER;
      ncnt_o <= `RST_COUNT;
    end
    else
    begin
      if (finish)
      begin
        ptr_o <= ptr_o + step;
        if (cnt_o != '0)
          cnt_o <= cnt_o - CNT_W'(1);
        if (cnt_o == CNT_W'(1) && ncnt_o != '0)
        begin
          ptr_o  <= nptr_o;
          cnt_o  <= ncnt_o;
          ncnt_o <= '0;
        end
      end
      if (wr_ptr_i) ptr_o <= wdata_i[PTR_W-1:0];
      if (wr_cnt_i) cnt_o <= wdata_i[CNT_W-1:0];
      if (wr_nptr_i) nptr_o <= wdata_i[PTR_W-1:0];
      if (wr_ncnt_i) ncnt_o <= wdata_i[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // End of transfer flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      end_o <= 1'b0;
    else if (finish && cnt_o == CNT_W'(1))
      end_o <= 1'b1;
    else if (wr_cnt_i || wr_ncnt_i)
      end_o <= 1'b0;
  end

  chk_zero_no_start: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (cnt_o == '0) |-> !start_o) else $error("start with zero count");
  chk_zero_no_wrap: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (finish && cnt_o == '0 && !wr_cnt_i) |=> (cnt_o == '0)) else $error("count wrapped");
  chk_count_step: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (finish && cnt_o > CNT_W'(1) && !wr_cnt_i) |=> (cnt_o == $past(cnt_o) - CNT_W'(1)))
    else $error("count did not decrement");
  chk_reload_next: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (finish && cnt_o == CNT_W'(1) && ncnt_o != '0 && !wr_ncnt_i && !wr_cnt_i)
    |=> (ncnt_o == '0 && cnt_o == $past(ncnt_o) && end_o)) else $error("reload wrong");
  chk_flag_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ((wr_cnt_i || wr_ncnt_i) && !finish) |=> !end_o) else $error("end flag not cleared");
endmodule
`default_nettype wire

// ### tb/dma_peer_model.sv
`default_nettype none
module dma_peer_model
#(
  parameter int DLY = 1
)
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ready_i,
  input  wire logic start_i,
  output logic      request_o,
  output logic      done_o,
  output var int    starts_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int wait_q;

  assign request_o = ready_i;

  // Finish each started transfer after DLY cycles
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      wait_q   <= 0;
      done_o   <= 1'b0;
      starts_o <= 0;
    end
    else
    begin
      done_o <= (wait_q == 1);
      if (start_i)
      begin
        wait_q   <= DLY;
        starts_o <= starts_o + 1;
      end
      else if (wait_q != 0)
        wait_q <= wait_q - 1;
    end
endmodule
`default_nettype wire

// ### tb/peripheral_dma_channel_regs_tb_top.sv
`include "dma_channel_map.svh"
`default_nettype none
module peripheral_dma_channel_regs_tb_top
  import dma_channel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        sel_i     = 1'b0;
  logic        write_i   = 1'b0;
  logic [11:0] addr_i    = 12'h000;
  logic [31:0] wdata_i   = 32'h0;
  logic [31:0] rdata_o;
  logic [31:0] rx_addr_o;
  logic [31:0] tx_addr_o;
  xfer_size_t  rx_size_i = SIZE_BYTE;
  xfer_size_t  tx_size_i = SIZE_WORD;
  logic        rx_ready  = 1'b0;
  logic        tx_ready  = 1'b0;
  logic        rx_request_i;
  logic        tx_request_i;
  logic        rx_done_i;
  logic        tx_done_i;
  logic        rx_start_o;
  logic        tx_start_o;
  logic        rx_end_o;
  logic        tx_end_o;
  int          rx_starts;
  int          tx_starts;
  int          fails     = 0;
  int          checked   = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  dma_channel_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sel_i(sel_i),
    .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rx_request_i(rx_request_i), .tx_request_i(tx_request_i), .rx_size_i(rx_size_i),
    .tx_size_i(tx_size_i), .rx_done_i(rx_done_i), .tx_done_i(tx_done_i),
    .rx_start_o(rx_start_o), .tx_start_o(tx_start_o), .rx_addr_o(rx_addr_o),
    .tx_addr_o(tx_addr_o), .rx_end_o(rx_end_o), .tx_end_o(tx_end_o));
  dma_peer_model #(.DLY(1)) rx_peer (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ready_i(rx_ready), .start_i(rx_start_o), .request_o(rx_request_i),
    .done_o(rx_done_i), .starts_o(rx_starts));
  dma_peer_model #(.DLY(4)) tx_peer (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ready_i(tx_ready), .start_i(tx_start_o), .request_o(tx_request_i),
    .done_o(tx_done_i), .starts_o(tx_starts));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    sel_i   <= 1'b1;
    write_i <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    sel_i   <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    sel_i   <= 1'b1;
    write_i <= 1'b0;
    addr_i  <= a;
    @(posedge ref_clk_i);
    sel_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    for (int i = 0; i < 10; i++)
    begin
      rd(12'h100 + 12'(4 * i), d);
      cmp(d, 32'h0, "reset value");
    end
    cmp({30'h0, rx_end_o, tx_end_o}, 32'h0, "end flags at reset");
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [31:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = 32'hc3a5_0000 + 32'(i * 4 + 2);
      wr(12'h100 + 12'(4 * i), v);
      rd(12'h100 + 12'(4 * i), d);
      cmp(d, (i % 2) ? {16'h0, v[15:0]} : v, "rw value");
      wr(12'h100 + 12'(4 * i), 32'h0);
    end
    rd(12'h128, d);
    cmp(d, 32'h0, "unmapped read");
    wr(`OFS_TRANSFER_ENABLE_STATUS, 32'h0000_0101);
    rd(`OFS_TRANSFER_ENABLE_STATUS, d);
    cmp(d, 32'h0, "status written");
  endtask

  task automatic t_zero();
    logic [31:0] d;
    wr(`OFS_TRANSFER_ENABLE_CTRL, 32'h0000_0101);
    rd(`OFS_TRANSFER_ENABLE_STATUS, d);
    cmp(d, 32'h0000_0101, "status after enable");
    rd(`OFS_TRANSFER_ENABLE_CTRL, d);
    cmp(d, 32'h0, "control read");
    wr(`OFS_TRANSFER_ENABLE_STATUS, 32'h0);
    rd(`OFS_TRANSFER_ENABLE_STATUS, d);
    cmp(d, 32'h0000_0101, "status kept");
    @(posedge ref_clk_i);
    rx_ready <= 1'b1;
    tx_ready <= 1'b1;
    repeat (30) @(posedge ref_clk_i);
    cmp(32'(rx_starts + tx_starts), 32'h0, "start with zero count");
    rx_ready <= 1'b0;
    tx_ready <= 1'b0;
  endtask

  task automatic t_rx(input xfer_size_t size, input int step);
    logic [31:0] d;
    int          n0;
    n0 = rx_starts;
    wr(`OFS_TRANSFER_ENABLE_CTRL, 32'h0000_0003);
    wr(`OFS_RX_BUFFER_POINTER, 32'h0000_1000);
    wr(`OFS_RX_TRANSFER_COUNT, 32'h0000_0003);
    wr(`OFS_RX_NEXT_BUFFER_POINTER, 32'h0000_2000);
    wr(`OFS_RX_NEXT_TRANSFER_COUNT, 32'h0000_0002);
    repeat (2) @(posedge ref_clk_i);
    cmp({31'h0, rx_end_o}, 32'h0, "end after count write");
    wr(`OFS_TRANSFER_ENABLE_CTRL, 32'h0000_0001);
    rx_size_i <= size;
    rx_ready  <= 1'b1;
    for (int i = 0; i < 300 && rx_starts - n0 < 5; i++)
      @(posedge ref_clk_i);
    repeat (20) @(posedge ref_clk_i);
    rx_ready <= 1'b0;
    cmp(32'(rx_starts - n0), 32'd5, "rx starts");
    cmp({31'h0, rx_end_o}, 32'h1, "rx end");
    rd(`OFS_RX_BUFFER_POINTER, d);
    cmp(d, 32'h2000 + 32'(2 * step), "rx pointer");
    cmp(rx_addr_o, 32'h2000 + 32'(2 * step), "rx address out");
    rd(`OFS_RX_TRANSFER_COUNT, d);
    cmp(d, 32'h0, "rx count");
    rd(`OFS_RX_NEXT_TRANSFER_COUNT, d);
    cmp(d, 32'h0, "rx next count");
  endtask

  task automatic t_tx();
    logic [31:0] d;
    wr(`OFS_TX_BUFFER_POINTER, 32'h0000_3000);
    wr(`OFS_TX_TRANSFER_COUNT, 32'h0000_0002);
    tx_ready <= 1'b1;
    for (int i = 0; i < 300 && tx_starts < 2; i++)
      @(posedge ref_clk_i);
    repeat (20) @(posedge ref_clk_i);
    tx_ready <= 1'b0;
    cmp(32'(tx_starts), 32'd2, "tx starts");
    cmp({31'h0, tx_end_o}, 32'h1, "tx end");
    rd(`OFS_TX_BUFFER_POINTER, d);
    cmp(d, 32'h0000_3008, "tx pointer");
    cmp(tx_addr_o, 32'h0000_3008, "tx address out");
    wr(`OFS_TX_TRANSFER_COUNT, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    cmp({31'h0, tx_end_o}, 32'h0, "tx end cleared");
  endtask

  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset();
    t_regs();
    t_zero();
    t_rx(SIZE_BYTE, 1);
    t_rx(SIZE_HALF, 2);
    t_tx();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
